// ===== verilog/fbc_host.v
// Host-side command sequencer for a parallel flash bus
`timescale 1ns/10ps
`default_nettype none
`include "fbc_defines.vh"
module fbc_host (
  input  wire                  clk,
  input  wire                  sys_rst,
  input  wire                  cmd_valid,
  input  wire [`FBC_CW-1:0]    cmd_op,
  input  wire [`FBC_AW-1:0]    cmd_addr,
  input  wire [`FBC_DW-1:0]    cmd_data,
  input  wire                  byte_mode,
  output reg                   cmd_ready,
  output reg                   rsp_valid,
  output reg  [`FBC_DW-1:0]    rsp_data,
  output reg  [`FBC_AW-1:0]    flash_addr,
  output reg  [`FBC_DW-1:0]    flash_dq_o,
  output reg                   flash_dq_oe,
  input  wire [`FBC_DW-1:0]    flash_dq_i,
  output reg                   flash_ce_n,
  output reg                   flash_oe_n,
  output reg                   flash_we_n,
  output reg                   flash_byte_n
);
  localparam ST_IDLE  = 2'd0;
  localparam ST_SETUP = 2'd1;
  localparam ST_PULSE = 2'd2;
  localparam ST_HOLD  = 2'd3;
  // Phase lengths in clocks, cut to the timer width on purpose
  localparam integer        T_SETUP_I = `FBC_CYC(`FBC_T_SETUP_NS);
  localparam integer        T_PULSE_I = `FBC_CYC(`FBC_T_PULSE_NS);
  localparam integer        T_HOLD_I  = `FBC_CYC(`FBC_T_HOLD_NS);
  localparam [`FBC_TCW-1:0] T_SETUP   = T_SETUP_I[`FBC_TCW-1:0];
  localparam [`FBC_TCW-1:0] T_PULSE   = T_PULSE_I[`FBC_TCW-1:0];
  localparam [`FBC_TCW-1:0] T_HOLD    = T_HOLD_I[`FBC_TCW-1:0];

  reg  [1:0]            st_q;
  reg  [`FBC_TCW-1:0]   tmr_q;
  reg  [2:0]            cyc_q;
  reg  [2:0]            ncyc_q;
  reg                   rd_q;
  reg  [`FBC_CW-1:0]    op_q;
  reg  [`FBC_AW-1:0]    addr_q;
  reg  [`FBC_DW-1:0]    data_q;
  reg                   bm_q;
  reg  [`FBC_AW-1:0]    seq_a;
  reg  [`FBC_DW-1:0]    seq_d;
  reg  [2:0]            seq_n;
  wire [`FBC_AW-1:0]    u1;
  wire [`FBC_AW-1:0]    u2;
  wire [`FBC_AW-1:0]    qa;

  // Unlock addresses depend on bus width
  assign u1 = bm_q ? `FBC_ADDR_U1_B : `FBC_ADDR_U1_W;
  assign u2 = bm_q ? `FBC_ADDR_U2_B : `FBC_ADDR_U2_W;
  assign qa = bm_q ? `FBC_ADDR_QRY_B : `FBC_ADDR_QRY_W;

  // Address and data of bus cycle cyc_q for the latched command
  always @* begin
    seq_a = addr_q;
    seq_d = data_q;
    seq_n = 3'd1;
    case (op_q)
      `FBC_OP_READ: begin
        seq_n = 3'd1;
      end
      `FBC_OP_RESET, `FBC_OP_BUF_ABORT: begin
        // Plain reset, or unlock pair then F0 at 555/AAA
        if (op_q == `FBC_OP_RESET) begin
          seq_d = {8'h00, `FBC_D_RESET};
        end else begin
          seq_n = 3'd3;
          seq_a = (cyc_q == 3'd0) ? u1 : (cyc_q == 3'd1) ? u2 : u1;
          seq_d = {8'h00, (cyc_q == 3'd0) ? `FBC_D_UNLOCK1 :
                          (cyc_q == 3'd1) ? `FBC_D_UNLOCK2 : `FBC_D_RESET};
        end
      end
      `FBC_OP_QUERY: begin
        seq_a = qa | (addr_q & ~`FBC_ADDR_U1_B);
        seq_d = {8'h00, `FBC_D_QUERY};
      end
      `FBC_OP_XREG_WR: begin
        seq_n = 3'd2;
        seq_a = (cyc_q == 3'd0) ? u1 : addr_q;
        seq_d = (cyc_q == 3'd0) ? {8'h00, `FBC_D_XREG_WR} : data_q;
      end
      `FBC_OP_XREG_RD: begin
        seq_a = u1;
        seq_d = {8'h00, `FBC_D_XREG_RD};
      end
      `FBC_OP_BUF_DATUM: begin
        seq_d = data_q;
      end
      `FBC_OP_BUF_CONF: begin
        seq_d = {8'h00, `FBC_D_BUF_CONFIRM};
      end
      default: begin
        // Unlocked sequences: unlock pair, code, optional fourth cycle
        seq_n = (op_q == `FBC_OP_PROGRAM || op_q == `FBC_OP_BUF_LOAD ||
                 op_q == `FBC_OP_SEC_EXIT) ? 3'd4 : 3'd3;
        case (cyc_q)
          3'd0: begin
            seq_a = u1;
            seq_d = {8'h00, `FBC_D_UNLOCK1};
          end
          3'd1: begin
            seq_a = u2;
            seq_d = {8'h00, `FBC_D_UNLOCK2};
          end
          3'd2: begin
            seq_a = (op_q == `FBC_OP_BUF_LOAD) ? addr_q :
                    (op_q == `FBC_OP_IDENT) ? (u1 | (addr_q & ~`FBC_ADDR_U1_B)) : u1;
            case (op_q)
              `FBC_OP_IDENT:     seq_d = {8'h00, `FBC_D_IDENT};
              `FBC_OP_SEC_ENTER: seq_d = {8'h00, `FBC_D_SEC_ENTER};
              `FBC_OP_SEC_EXIT:  seq_d = {8'h00, `FBC_D_IDENT};
              `FBC_OP_PROGRAM:   seq_d = {8'h00, `FBC_D_PROGRAM};
              default:           seq_d = {8'h00, `FBC_D_BUF_LOAD};
            endcase
          end
          default: begin
            // Fourth cycle: datum, count minus one, or exit code
            seq_a = addr_q;
            seq_d = (op_q == `FBC_OP_SEC_EXIT) ? {8'h00, `FBC_D_SEC_EXIT2} : data_q;
          end
        endcase
      end
    endcase
  end

  // Bus cycle sequencer
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_q <= ST_IDLE;
      tmr_q <= 4'h0;
      cyc_q <= 3'd0;
      ncyc_q <= 3'd1;
      rd_q <= 1'b0;
      op_q <= `FBC_OP_READ;
      addr_q <= 26'h0000000;
      data_q <= 16'h0000;
      bm_q <= 1'b0;
      cmd_ready <= 1'b1;
      rsp_valid <= 1'b0;
      rsp_data <= 16'h0000;
      flash_addr <= 26'h0000000;
      flash_dq_o <= 16'h0000;
      flash_dq_oe <= 1'b0;
      flash_ce_n <= 1'b1;
      flash_oe_n <= 1'b1;
      flash_we_n <= 1'b1;
      flash_byte_n <= 1'b1;
    end else begin
      rsp_valid <= 1'b0;
      case (st_q)
        ST_IDLE: begin
          if (cmd_valid) begin
            op_q <= cmd_op;
            addr_q <= cmd_addr;
            data_q <= cmd_data;
            bm_q <= byte_mode;
            flash_byte_n <= ~byte_mode;
            rd_q <= (cmd_op == `FBC_OP_READ);
            cyc_q <= 3'd0;
            cmd_ready <= 1'b0;
            tmr_q <= 4'h0;
            st_q <= ST_SETUP;
          end
        end
        ST_SETUP: begin
          // Present address and data, chip enabled
          ncyc_q <= seq_n;
          flash_addr <= seq_a;
          flash_dq_o <= seq_d;
          flash_dq_oe <= ~rd_q;
          flash_ce_n <= 1'b0;
          if (tmr_q + 4'h1 >= T_SETUP) begin
            tmr_q <= 4'h0;
            st_q <= ST_PULSE;
            flash_we_n <= rd_q;
            flash_oe_n <= ~rd_q;
          end else begin
            tmr_q <= tmr_q + 4'h1;
          end
        end
        ST_PULSE: begin
          if (tmr_q + 4'h1 >= T_PULSE) begin
            tmr_q <= 4'h0;
            st_q <= ST_HOLD;
            flash_we_n <= 1'b1;
            flash_oe_n <= 1'b1;
            if (rd_q) begin
              rsp_data <= flash_dq_i;
            end
          end else begin
            tmr_q <= tmr_q + 4'h1;
          end
        end
        default: begin
          // Hold, then next bus cycle or finish
          if (tmr_q + 4'h1 >= T_HOLD) begin
            tmr_q <= 4'h0;
            flash_dq_oe <= 1'b0;
            flash_ce_n <= 1'b1;
            if (cyc_q + 3'd1 < ncyc_q) begin
              cyc_q <= cyc_q + 3'd1;
              st_q <= ST_SETUP;
            end else begin
              rsp_valid <= 1'b1;
              cmd_ready <= 1'b1;
              st_q <= ST_IDLE;
            end
          end else begin
            tmr_q <= tmr_q + 4'h1;
          end
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// ===== verilog/fbc_defines.vh
// Command codes, unlock addresses and bus timing for the flash command host
`ifndef FBC_DEFINES_VH
`define FBC_DEFINES_VH
`define FBC_AW            26
`define FBC_DW            16
`define FBC_CW            4
`define FBC_ADDR_U1_W     26'h0000555
`define FBC_ADDR_U2_W     26'h00002AA
`define FBC_ADDR_U1_B     26'h0000AAA
`define FBC_ADDR_U2_B     26'h0000555
`define FBC_ADDR_QRY_W    26'h0000055
`define FBC_ADDR_QRY_B    26'h00000AA
`define FBC_D_UNLOCK1     8'hAA
`define FBC_D_UNLOCK2     8'h55
`define FBC_D_RESET       8'hF0
`define FBC_D_IDENT       8'h90
`define FBC_D_QUERY       8'h98
`define FBC_D_SEC_ENTER   8'h88
`define FBC_D_SEC_EXIT2   8'h00
`define FBC_D_XREG_WR     8'h70
`define FBC_D_XREG_RD     8'h71
`define FBC_D_PROGRAM     8'hA0
`define FBC_D_BUF_LOAD    8'h25
`define FBC_D_BUF_CONFIRM 8'h29
// Command codes on cmd_op
`define FBC_OP_READ       4'h0
`define FBC_OP_RESET      4'h1
`define FBC_OP_IDENT      4'h2
`define FBC_OP_QUERY      4'h3
`define FBC_OP_SEC_ENTER  4'h4
`define FBC_OP_SEC_EXIT   4'h5
`define FBC_OP_XREG_WR    4'h6
`define FBC_OP_XREG_RD    4'h7
`define FBC_OP_PROGRAM    4'h8
`define FBC_OP_BUF_LOAD   4'h9
`define FBC_OP_BUF_DATUM  4'hA
`define FBC_OP_BUF_CONF   4'hB
`define FBC_OP_BUF_ABORT  4'hC
// Bus cycle phase lengths in ns, and cycles at 25 MHz (rounded up)
`define FBC_CLK_NS        40
`define FBC_T_SETUP_NS    40
`define FBC_T_PULSE_NS    80
`define FBC_T_HOLD_NS     40
`define FBC_CYC(ns)       (((ns) + `FBC_CLK_NS - 1) / `FBC_CLK_NS)
`define FBC_TCW           4
`endif

// ===== tb/fbc_host_props.sv
// Bus timing checker for the flash command host
`timescale 1ns/10ps
`default_nettype none
`include "fbc_defines.vh"
module fbc_host_props (
  input wire              clk,
  input wire              sys_rst,
  input wire              cmd_valid,
  input wire [3:0]        cmd_op,
  input wire              cmd_ready,
  input wire              rsp_valid,
  input wire              byte_mode,
  input wire [25:0]       flash_addr,
  input wire [15:0]       flash_dq_o,
  input wire              flash_dq_oe,
  input wire              flash_ce_n,
  input wire              flash_oe_n,
  input wire              flash_we_n,
  input wire              flash_byte_n
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  // Request taken this edge
  wire take = cmd_valid && cmd_ready;
  // Strobe low for two cycles then back high
  sequence s_we2; !flash_we_n ##1 !flash_we_n ##1 flash_we_n; endsequence
  sequence s_oe2; !flash_oe_n ##1 !flash_oe_n ##1 flash_oe_n; endsequence
  a_take_busy: assert property (take |=> !cmd_ready) else $error("ready stays high");
  a_idle_quiet: assert property (cmd_ready |-> flash_ce_n && flash_we_n && flash_oe_n
    && !flash_dq_oe) else $error("bus active while idle");
  a_we_width: assert property ($fell(flash_we_n) |-> s_we2) else $error("write pulse");
  a_oe_width: assert property ($fell(flash_oe_n) |-> s_oe2) else $error("read pulse");
  a_we_drives: assert property (!flash_we_n |-> flash_dq_oe && !flash_ce_n && flash_oe_n)
    else $error("write without drive");
  a_byte_pin: assert property (!flash_ce_n |-> flash_byte_n == !byte_mode)
    else $error("bus width pin");
  a_rsp_pulse: assert property (rsp_valid |-> cmd_ready ##1 !rsp_valid)
    else $error("answer pulse");
  a_read_time: assert property (take && cmd_op == `FBC_OP_READ |-> ##5 rsp_valid)
    else $error("read latency");
  a_reset_code: assert property (take && cmd_op == `FBC_OP_RESET |-> ##[1:4]
    (!flash_we_n && flash_dq_o[7:0] == 8'hF0)) else $error("reset code");
  a_query_word: assert property (take && cmd_op == `FBC_OP_QUERY && !byte_mode |-> ##[1:4]
    (!flash_we_n && flash_addr[7:0] == 8'h55 && flash_dq_o[7:0] == 8'h98))
    else $error("query write");
  a_prog_time: assert property (take && cmd_op == `FBC_OP_PROGRAM |-> ##17 rsp_valid)
    else $error("program latency");
endmodule
bind fbc_host fbc_host_props u_props (.clk, .sys_rst, .cmd_valid, .cmd_op, .cmd_ready,
  .rsp_valid, .byte_mode, .flash_addr, .flash_dq_o, .flash_dq_oe, .flash_ce_n, .flash_oe_n,
  .flash_we_n, .flash_byte_n);
`default_nettype wire

// ===== tb/fbc_flash_model.sv
// Behavioural flash device answering the host's bus cycles
`timescale 1ns/10ps
`default_nettype none
module fbc_flash_model (
  input wire [25:0]       flash_addr,
  input wire [15:0]       flash_dq_o,
  input wire              flash_dq_oe,
  output wire [15:0]      flash_dq_i,
  input wire              flash_ce_n,
  input wire              flash_oe_n,
  input wire              flash_we_n
);
  logic [25:0] wr_addr[$];
  logic [15:0] wr_data[$];
  logic [7:0]  last_cmd = 8'h00;
  logic        in_sec = 1'b0;
  logic        lock_bit = 1'b1;
  // Log each write on the rising strobe; lock bit has no clearing path
  always @(posedge flash_we_n) if (flash_ce_n === 1'b0 && flash_dq_oe === 1'b1) begin
    wr_addr.push_back(flash_addr);
    wr_data.push_back(flash_dq_o);
    if (flash_dq_o[7:0] == 8'h88) in_sec = 1'b1;
    else if (flash_dq_o[7:0] == 8'hF0 || (flash_dq_o[7:0] == 8'h00 && last_cmd == 8'h90))
      in_sec = 1'b0;
    last_cmd = flash_dq_o[7:0];
  end
  // Lock register in the region, else array pattern; inverted when not read
  wire [15:0] rd_val = in_sec ? {9'h000, lock_bit, 6'h00} : flash_addr[15:0] ^ 16'hC3A5;
  assign flash_dq_i = (!flash_ce_n && !flash_oe_n) ? rd_val : ~rd_val;
endmodule
`default_nettype wire

// ===== tb/tb.sv
// Self-checking bench for the flash command host
`timescale 1ns/10ps
`default_nettype none
`include "fbc_defines.vh"
module tb;
  logic        clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        cmd_valid = 1'b0;
  logic [3:0]  cmd_op = 4'h0;
  logic [25:0] cmd_addr = 26'h0000000;
  logic [15:0] cmd_data = 16'h0000;
  logic        byte_mode = 1'b0;
  wire         cmd_ready, rsp_valid, flash_dq_oe, flash_ce_n, flash_oe_n, flash_we_n;
  wire         flash_byte_n;
  wire  [15:0] rsp_data, flash_dq_o, flash_dq_i;
  wire  [25:0] flash_addr;
  int          miscompares = 0, checked = 0, cyc = 0, base;
  always #20 clk = ~clk;
  fbc_host uut (.clk, .sys_rst, .cmd_valid, .cmd_op, .cmd_addr, .cmd_data, .byte_mode,
    .cmd_ready, .rsp_valid, .rsp_data, .flash_addr, .flash_dq_o, .flash_dq_oe, .flash_dq_i,
    .flash_ce_n, .flash_oe_n, .flash_we_n, .flash_byte_n);
  fbc_flash_model m (.flash_addr, .flash_dq_o, .flash_dq_oe, .flash_dq_i, .flash_ce_n,
    .flash_oe_n, .flash_we_n);
  task automatic check(input logic [25:0] s, input logic [25:0] e);
    checked++;
    if (s !== e) begin
      miscompares++;
      $display("[FAIL] %0t seen %h expected %h", $time, s, e);
    end
  endtask
  // Issue one command and time its answer
  task automatic cmd(input logic [3:0] op, input logic [25:0] a, input logic [15:0] d, int n);
    int k = 1; // Take edge counts as the first
    base = m.wr_data.size();
    cmd_op = op;
    cmd_addr = a;
    cmd_data = d;
    cmd_valid = 1'b1;
    @(posedge clk);
    #1 cmd_valid = 1'b0;
    while (rsp_valid !== 1'b1 && k < 40) begin @(posedge clk); #1 k++; end
    check(k, 4 * n + 1);
  endtask
  task automatic ex(input int k, input logic [25:0] a, input logic [7:0] d);
    check(m.wr_addr[base + k], a);
    check(m.wr_data[base + k][7:0], d);
  endtask
  task automatic t_reset_read;
    cmd(`FBC_OP_RESET, 26'h0001234, 16'h0000, 1);
    ex(0, 26'h0001234, 8'hF0);
    cmd(`FBC_OP_READ, 26'h0000ABC, 16'h0000, 1);
    check(rsp_data, 16'h0ABC ^ 16'hC3A5);
  endtask
  task automatic t_ident_query;
    for (int b = 0; b < 2; b++) begin
      byte_mode = b[0];
      cmd(`FBC_OP_IDENT, 26'h0000000, 16'h0000, 3);
      ex(0, b ? 26'h0000AAA : 26'h0000555, 8'hAA);
      ex(1, b ? 26'h0000555 : 26'h00002AA, 8'h55);
      ex(2, b ? 26'h0000AAA : 26'h0000555, 8'h90);
      cmd(`FBC_OP_QUERY, 26'h0000000, 16'h0000, 1);
      ex(0, b ? 26'h00000AA : 26'h0000055, 8'h98);
    end
    byte_mode = 1'b0;
  endtask
  task automatic t_secure;
    cmd(`FBC_OP_SEC_ENTER, 26'h0000000, 16'h0000, 3);
    ex(2, 26'h0000555, 8'h88);
    cmd(`FBC_OP_READ, 26'h0000100, 16'h0000, 1);
    check(rsp_data[6], 1'b1);
    cmd(`FBC_OP_SEC_EXIT, 26'h0000000, 16'h0000, 4);
    ex(2, 26'h0000555, 8'h90);
    check(m.wr_data[base + 3], 16'h0000);
    cmd(`FBC_OP_READ, 26'h0000100, 16'h0000, 1);
    check(rsp_data, 16'h0100 ^ 16'hC3A5);
  endtask
  task automatic t_xreg_prog;
    cmd(`FBC_OP_XREG_WR, 26'h0000000, 16'h00A5, 2);
    ex(0, 26'h0000555, 8'h70);
    check(m.wr_data[base + 1], 16'h00A5);
    cmd(`FBC_OP_XREG_RD, 26'h0000000, 16'h0000, 1);
    ex(0, 26'h0000555, 8'h71);
    cmd(`FBC_OP_PROGRAM, 26'h0012345, 16'hBEEF, 4);
    ex(2, 26'h0000555, 8'hA0);
    check(m.wr_addr[base + 3], 26'h0012345);
    check(m.wr_data[base + 3], 16'hBEEF);
  endtask
  task automatic t_buffer;
    cmd(`FBC_OP_BUF_LOAD, 26'h0030000, 16'h0001, 4);
    ex(2, 26'h0030000, 8'h25);
    ex(3, 26'h0030000, 8'h01);
    for (int i = 0; i < 2; i++) begin
      cmd(`FBC_OP_BUF_DATUM, 26'h0030000 + i, 16'h1111 * (i + 1), 1);
      check(m.wr_addr[base], 26'h0030000 + i);
      check(m.wr_data[base], 16'h1111 * (i + 1));
    end
    cmd(`FBC_OP_BUF_CONF, 26'h0030000, 16'h0000, 1);
    ex(0, 26'h0030000, 8'h29);
    cmd(`FBC_OP_BUF_ABORT, 26'h0000000, 16'h0000, 3);
    ex(2, 26'h0000555, 8'hF0);
  endtask
  task automatic test_done;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // Cut a hang short
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      miscompares++;
      test_done;
    end
  end
  initial begin
    repeat (3) @(posedge clk);
    #1 sys_rst = 1'b0;
    t_reset_read;
    t_ident_query;
    t_secure;
    t_xreg_prog;
    t_buffer;
    test_done;
  end
endmodule
`default_nettype wire
